//--- verilog/measurement_balance_pause_ctrl.v
// measurement acquisition and balancing pause control registers
// Operation
// (RULE1) pause length field bits 15:2, duration is value times 10 us
// (RULE2) new pause length affects only later pauses, not a running one
// (RULE3) length zero means no pause and is reset; 3FFFh gives 163830 us
// (RULE4) auto-pause enable bit 1 delays cyclic-mode measurement start
// (RULE5) acquisition enable bit 0; writing zero clears all results and ready flags
// (RULE6) acquisition enable cleared automatically on entering sleep
// (RULE7) cyclic measurements run regardless of acquisition enable
// (RULE8) enabling acquisition never pauses balancing by itself
// (RULE9) pause bit 15 suspends balancing during the capture cycle it starts
// (RULE10) pause from unpaused balancing delays capture until pause timer ends
// (RULE11) pause request without any capture bit is ignored
// (RULE12) open-load channel select bits 14:10, read/write, resets to 1Fh
// (RULE13) command register 1801h capture bits 9..0, write-only, reset zero
// (RULE14) writing one to a capture bit captures that group, zero nothing
// (RULE15) open-load field written only together with cell voltage capture
// (RULE16) aux 4..7 captures with pause still force a balancing pause
// (RULE17) write-only command bits are one-cycle pulses and read zero; pause bit 15 holds balance_pause_request until the sequencer is idle again
`timescale 1ns/10ps
`include "meas_ctrl_regs.vh"
module measurement_balance_pause_ctrl #(
  parameter LEN_W = 14,
  parameter CAP_W = 10,
  parameter STEP_CYCLES = `STEP_CYCLES
) (
  input wire clock,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire sleep_entry,
  input wire cyclic_entry,
  input wire cyclic_request,
  input wire balance_paused,
  output reg acquisition_enable,
  output reg cyclic_auto_pause_enable,
  output reg [LEN_W-1:0] balance_pause_length,
  output reg [4:0] open_load_channel_select,
  output reg results_clear,
  output reg balance_pause_request,
  output reg [CAP_W-1:0] capture_start,
  output reg cyclic_measure_start
);
  // ----------------------------------------------------------------
  // reset synchroniser and pin input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] rst_sync_q;
  reg [2:0] in_meta_q;
  reg [2:0] in_sync_q;
  reg sleep_prev_q;
  wire rst_n;
  wire sleep_s;
  wire cyc_entry_s;
  wire cyc_req_s;

  assign rst_n = rst_sync_q[1];
  assign sleep_s = in_sync_q[0];
  assign cyc_entry_s = in_sync_q[1];
  assign cyc_req_s = in_sync_q[2];

  // release reset through two flip-flops
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // two-stage sync of external mode strobes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= 3'b000;
      in_sync_q <= 3'b000;
      sleep_prev_q <= 1'b0;
    end else begin
      in_meta_q <= {cyclic_request, cyclic_entry, sleep_entry};
      in_sync_q <= in_meta_q;
      sleep_prev_q <= sleep_s;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_cfg;
  wire wr_cmd;
  wire [CAP_W-1:0] cap_bits;
  wire pause_bit;
  wire any_cap;
  wire sleep_rise;

  assign wr_cfg = reg_wr && (reg_addr == `ADDR_MEAS_CFG);
  assign wr_cmd = reg_wr && (reg_addr == `ADDR_APP_CMD);
  assign cap_bits = reg_wdata[`CMD_CAP_HI:`CMD_CAP_LO]; // RULE13
  assign pause_bit = reg_wdata[`CMD_PAUSE_BIT];
  assign any_cap = |cap_bits;
  assign sleep_rise = sleep_s && !sleep_prev_q;

  // configuration register and open-load selector
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      balance_pause_length <= `LEN_RESET; // RULE3
      cyclic_auto_pause_enable <= 1'b0; // RULE4
      acquisition_enable <= 1'b0; // RULE5
      open_load_channel_select <= `OL_RESET; // RULE12
      results_clear <= 1'b0;
    end else begin
      results_clear <= 1'b0;
      if (wr_cfg) begin
        balance_pause_length <= reg_wdata[`CFG_LEN_HI:`CFG_LEN_LO]; // RULE1
        cyclic_auto_pause_enable <= reg_wdata[`CFG_AUTO_BIT];
        acquisition_enable <= reg_wdata[`CFG_ACQ_BIT];
        results_clear <= !reg_wdata[`CFG_ACQ_BIT]; // RULE5
      end
      if (sleep_rise) begin
        acquisition_enable <= 1'b0; // RULE6
        results_clear <= 1'b1;
      end
      if (wr_cmd && reg_wdata[`CMD_VC_BIT]) begin
        open_load_channel_select <= reg_wdata[`CMD_OL_HI:`CMD_OL_LO]; // RULE15
      end
    end
  end

  // read mux; write-only command bits read as zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_addr == `ADDR_MEAS_CFG) begin
      reg_rdata <= {balance_pause_length, cyclic_auto_pause_enable, acquisition_enable};
    end else if (reg_rd && reg_addr == `ADDR_APP_CMD) begin
      reg_rdata <= {1'b0, open_load_channel_select, 10'h000}; // RULE17
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // capture sequencer with pause handling
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_q;
  reg [CAP_W-1:0] pend_q;
  reg pend_cyclic_q;
  reg timer_start;
  wire timer_busy;
  wire timer_done;

  pause_timer #(.LEN_W(LEN_W), .STEP_CYCLES(STEP_CYCLES)) u_pause (
    .clock(clock),
    .rst_n(rst_n),
    .start(timer_start),
    .length(balance_pause_length), // RULE2
    .busy(timer_busy),
    .done(timer_done)
  );

  // pause requested only with a capture bit, aux 4..7 included
  wire cmd_pause;
  assign cmd_pause = wr_cmd && pause_bit && any_cap; // RULE11 RULE16 RULE9

  always @* begin
    timer_start = 1'b0;
    if (state_q == ST_IDLE) begin
      if (cmd_pause && !balance_paused) begin
        timer_start = 1'b1; // RULE10
      end else if (cyc_entry_s && cyclic_auto_pause_enable) begin
        timer_start = 1'b1; // RULE4
      end
    end
  end

  // sequencer: commands pulse once, cyclic run independent of enable
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pend_q <= {CAP_W{1'b0}};
      pend_cyclic_q <= 1'b0;
      capture_start <= {CAP_W{1'b0}};
      cyclic_measure_start <= 1'b0;
      balance_pause_request <= 1'b0;
    end else begin
      capture_start <= {CAP_W{1'b0}}; // RULE17
      cyclic_measure_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          balance_pause_request <= 1'b0; // RULE8
          if (timer_start) begin
            pend_q <= cmd_pause ? cap_bits : {CAP_W{1'b0}};
            pend_cyclic_q <= !cmd_pause;
            balance_pause_request <= cmd_pause; // RULE9
            state_q <= ST_WAIT;
          end else if (wr_cmd && any_cap) begin
            capture_start <= cap_bits; // RULE14
            balance_pause_request <= pause_bit;
            state_q <= pause_bit ? ST_RUN : ST_IDLE;
          end else if (cyc_req_s) begin
            cyclic_measure_start <= 1'b1; // RULE7
          end
        end
        ST_WAIT: begin
          if (timer_done) begin
            capture_start <= pend_q; // RULE10
            cyclic_measure_start <= pend_cyclic_q; // RULE4
            state_q <= (pend_q != {CAP_W{1'b0}}) ? ST_RUN : ST_IDLE;
          end
        end
        ST_RUN: begin
          // one cycle hold standing for the capture cycle
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // measurement_balance_pause_ctrl

//--- shared/meas_ctrl_regs.vh
// register map and timing constants of the measurement balance pause control
`ifndef MEAS_CTRL_REGS_VH
`define MEAS_CTRL_REGS_VH
`define ADDR_MEAS_CFG 16'h1800
`define ADDR_APP_CMD 16'h1801
`define CFG_LEN_HI 15
`define CFG_LEN_LO 2
`define CFG_AUTO_BIT 1
`define CFG_ACQ_BIT 0
`define CMD_PAUSE_BIT 15
`define CMD_OL_HI 14
`define CMD_OL_LO 10
`define CMD_CAP_HI 9
`define CMD_CAP_LO 0
`define CMD_VC_BIT 0
`define CMD_AUX_HI_HI 9
`define CMD_AUX_HI_LO 6
`define LEN_RESET 14'h0000
`define OL_RESET 5'h1F
`define PAUSE_STEP_NS 10000
`define CLOCK_PERIOD_NS 5
`define STEP_CYCLES (`PAUSE_STEP_NS / `CLOCK_PERIOD_NS)
`endif

//--- verilog/pause_step_tick.v
// free running tick generator, one pulse per pause step
`timescale 1ns/10ps
`include "meas_ctrl_regs.vh"
module pause_step_tick #(
  parameter STEP_CYCLES = `STEP_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire restart,
  output reg tick
);
  reg [15:0] cnt_q;

  // count down one step, restart aligns step to pause start
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_q <= STEP_CYCLES[15:0] - 16'h0001;
      tick <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= STEP_CYCLES[15:0] - 16'h0001;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // pause_step_tick

//--- verilog/pause_timer.v
// balancing pause timer counting whole pause steps
`timescale 1ns/10ps
`include "meas_ctrl_regs.vh"
module pause_timer #(
  parameter LEN_W = 14,
  parameter STEP_CYCLES = `STEP_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire start,
  input wire [LEN_W-1:0] length,
  output reg busy,
  output reg done
);
  reg [LEN_W-1:0] left_q;
  wire tick;

  pause_step_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .restart(start),
    .tick(tick)
  );

  // length is latched at start so later writes do not alter a running pause
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= {LEN_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        if (length == {LEN_W{1'b0}}) begin
          done <= 1'b1; // zero length means no pause
        end else begin
          left_q <= length;
          busy <= 1'b1;
        end
      end else if (busy && tick) begin
        if (left_q == {{(LEN_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        left_q <= left_q - {{(LEN_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // pause_timer

//--- tb/meas_pause_monitor.sv
// assertions on the ports of the measurement balance pause control
`timescale 1ns/10ps
module meas_pause_monitor #(
  parameter LEN_W = 14,
  parameter CAP_W = 10,
  parameter STEP_CYCLES = 4
) (
  input wire clock,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire sleep_entry,
  input wire balance_paused,
  input wire acquisition_enable,
  input wire cyclic_auto_pause_enable,
  input wire [LEN_W-1:0] balance_pause_length,
  input wire [4:0] open_load_channel_select,
  input wire results_clear,
  input wire balance_pause_request,
  input wire [CAP_W-1:0] capture_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  reg bpr_q;
  reg [31:0] cnt_q;
  reg [31:0] lim_q;
  // cycles since the pause request rose, and the wait then due
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bpr_q <= 1'h0;
      cnt_q <= 32'h0;
      lim_q <= 32'h0;
    end else begin
      bpr_q <= balance_pause_request;
      cnt_q <= (balance_pause_request && !bpr_q) ? 32'h0 : cnt_q + 32'h1;
      if (balance_pause_request && !bpr_q) lim_q <= balance_pause_length * STEP_CYCLES;
    end
  end
  a_config_store: assert property (reg_wr && reg_addr == 16'h1800 |=>
    balance_pause_length == $past(reg_wdata[15:2])
    && cyclic_auto_pause_enable == $past(reg_wdata[1])) else $error("config not stored");
  a_clear_on_disable: assert property (reg_wr && reg_addr == 16'h1800
    && !reg_wdata[0] |=> results_clear && !acquisition_enable) else $error("no result clear");
  a_sleep_clears: assert property ($rose(sleep_entry) |-> ##[1:6] !acquisition_enable)
    else $error("sleep kept acquisition");
  a_cfg_readback: assert property (reg_rd && reg_addr == 16'h1800 |=> reg_rdata ==
    {$past(balance_pause_length), $past(cyclic_auto_pause_enable), $past(acquisition_enable)})
    else $error("config read wrong");
  a_cmd_readback: assert property (reg_rd && reg_addr == 16'h1801 |=>
    reg_rdata == {1'h0, $past(open_load_channel_select), 10'h000}) else $error("command read");
  a_ol_needs_vc: assert property (reg_wr && reg_addr == 16'h1801 && !reg_wdata[0]
    |=> $stable(open_load_channel_select)) else $error("open-load written alone");
  a_pause_ignored: assert property (reg_wr && reg_addr == 16'h1801
    && reg_wdata[9:0] == 10'h000 |=> !$rose(balance_pause_request)) else $error("lone pause");
  a_pause_wait: assert property (capture_start != 0 && balance_pause_request
    && !balance_paused |-> cnt_q + 2 >= lim_q && cnt_q <= lim_q + STEP_CYCLES + 4)
    else $error("capture off pause");
endmodule // meas_pause_monitor
bind measurement_balance_pause_ctrl meas_pause_monitor #(.LEN_W(LEN_W), .CAP_W(CAP_W),
  .STEP_CYCLES(STEP_CYCLES)) i_mon (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .sleep_entry, .balance_paused, .acquisition_enable, .cyclic_auto_pause_enable,
  .balance_pause_length, .open_load_channel_select, .results_clear, .balance_pause_request,
  .capture_start);

//--- tb/measurement_balance_pause_ctrl_tb.sv
// self-checking bench of the measurement balance pause control
`timescale 1ns/10ps
module measurement_balance_pause_ctrl_tb;
  localparam int STEP = 4;
  logic clock = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sleep_entry = 1'h0;
  logic cyclic_entry = 1'h0, cyclic_request = 1'h0, balance_paused = 1'h0;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, d;
  wire [15:0] reg_rdata;
  wire acquisition_enable, cyclic_auto_pause_enable, results_clear;
  wire balance_pause_request, cyclic_measure_start;
  wire [13:0] balance_pause_length;
  wire [4:0] open_load_channel_select;
  wire [9:0] capture_start;
  int failures = 0, checks_done = 0, n, i, seed = 32'hD6A0;
  measurement_balance_pause_ctrl #(.STEP_CYCLES(STEP)) i_dut (.clock, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_entry, .cyclic_entry, .cyclic_request,
    .balance_paused, .acquisition_enable, .cyclic_auto_pause_enable, .balance_pause_length,
    .open_load_channel_select, .results_clear, .balance_pause_request, .capture_start,
    .cyclic_measure_start);
  // free running clock
  initial begin
    forever #2.5 clock = ~clock;
  end
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register write, outputs settled on return
  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1;
    check(reg_rdata, exp);
  endtask
  // bounded wait for a capture or a cyclic start pulse
  task wait_on(input bit cyc, output int cnt);
    cnt = 0;
    while ((cyc ? cyclic_measure_start : |capture_start) !== 1'h1) begin
      @(posedge clock);
      #1;
      cnt++;
      if (cnt > 100) begin
        failures++;
        stop_test;
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'h1;
    repeat (5) @(posedge clock);
    #1;
    check(open_load_channel_select, 16'h001F);
    rd(16'h1800, 16'h0000);
    rd(16'h1801, 16'h7C00);
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wr(16'h1800, d);
      check(balance_pause_length, d[15:2]);
      check(cyclic_auto_pause_enable, d[1]);
      check({results_clear, acquisition_enable}, {~d[0], d[0]});
      check(balance_pause_request, 1'h0);
      rd(16'h1800, d);
    end
    wr(16'h1802, 16'h0000);
    check(balance_pause_length, d[15:2]);
    wr(16'h1801, 16'h9400);
    repeat (6) begin
      @(posedge clock);
      #1;
      check({balance_pause_request, capture_start}, 16'h0000);
    end
    check(open_load_channel_select, 16'h001F);
    for (i = 0; i < 10; i++) begin
      wr(16'h1801, 16'({i[4:0] + 5'h08, 10'h000}) | (16'h0001 << i));
      wait_on(1'h0, n);
      check({balance_pause_request, capture_start}, 16'h0001 << i);
      check(open_load_channel_select, 16'h0008);
      rd(16'h1801, 16'h2000);
    end
    wr(16'h1800, 16'h000D);
    d = 16'h8000 | (16'h0040 << ($unsigned($random(seed)) % 4));
    wr(16'h1801, d);
    wr(16'h1800, 16'h0005);
    wr(16'h1801, 16'h0002);
    check(balance_pause_request, 1'h1);
    wait_on(1'h0, n);
    check(capture_start, d[9:0]);
    check(n + 6 >= 3 * STEP && n + 6 <= 4 * STEP + 6, 1'h1);
    repeat (8) begin
      @(posedge clock);
      #1;
      check(capture_start, 16'h0000);
    end
    @(posedge clock) balance_paused <= 1'h1;
    wr(16'h1801, 16'h8001);
    wait_on(1'h0, n);
    check(n < 4, 1'h1);
    @(posedge clock) balance_paused <= 1'h0;
    wr(16'h1800, 16'h0001);
    @(posedge clock) sleep_entry <= 1'h1;
    for (i = 0; i < 10 && acquisition_enable; i++) @(posedge clock);
    #1;
    check(acquisition_enable, 1'h0);
    sleep_entry <= 1'h0;
    wr(16'h1800, 16'h000A);
    @(posedge clock) cyclic_entry <= 1'h1;
    wait_on(1'h1, n);
    check(n >= 2 * STEP, 1'h1);
    @(posedge clock) cyclic_entry <= 1'h0;
    wr(16'h1800, 16'h0000);
    @(posedge clock) cyclic_request <= 1'h1;
    wait_on(1'h1, n);
    check(acquisition_enable, 1'h0);
    @(posedge clock) cyclic_request <= 1'h0;
    stop_test;
  end
endmodule // measurement_balance_pause_ctrl_tb
